// ==== hw/omc_mode_ctrl.sv ====
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "omc_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Slow crystal starts high drive, lowers when stable
// - Exactly one mode; reset or interrupt wakes
// - Hardware stabilisation wait on SLOW to NORMAL
// - Slow clock drives system until NORMAL or LIGHT_SLEEP_FAST reached
// - Light_sleep_fast/1 keep oscillators; deep_sleep_from_fast/3 only RTC
// - Wake interrupt restores pre-halt mode and clocks
// - From NORMAL: light_sleep_fast, or deep_sleep_from_fast with fast off
// - From SLOW: light_sleep_slow or deep_sleep_from_slow by depth
// - NORMAL single write to light_sleep_slow or deep_sleep_from_slow
// - SLOW single write to light_sleep_fast or deep_sleep_from_fast
// - Wake needs level below mask at entry
// - Stop halts all oscillation and CPU
// - Stop clears watchdog; stabilise before it counts
// - Stop request: full_stop_fast from NORMAL, full_stop_slow SLOW
// - Single write crosses to full_stop_slow or full_stop_fast
// - Mode control bit layout as fixed
// - Reject stop with halt, slow clock disabled
// - Mode to clock source and gating map
//////////////////////////////////////////////////////////////////////////////
module omc_mode_ctrl
	import omc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        fast_osc_stable,
	input  wire logic        slow_osc_stable,
	input  wire logic        wake_req,
	input  wire logic [1:0]  source_irq_level,
	input  wire logic [1:0]  cpu_irq_mask_level,
	output logic             fast_osc_run,
	output logic             slow_osc_run,
	output logic             slow_osc_high_drive,
	output logic             ext_fast_osc_enable,
	output logic             fast_source_select,
	output logic             ext_slow_osc_enable,
	output logic             slow_source_select,
	output logic             system_clock_out_sel_fast,
	output logic             system_clock_out_gate_en,
	output logic             cpu_clk_en,
	output logic             rtc_clk_en,
	output logic             watchdog_clear,
	output logic             watchdog_run
);
	import omc_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Bus slave state
	logic        ap_wr_q;      // Write data phase pending
	logic [31:0] ap_addr_q;    // Latched word address
	logic        ap_take;      // Valid address phase
	logic        wr_mode;      // Mode control write this cycle
	// Register state
	logic [5:0]  mode_control_register_q;
	logic [3:0]  osc_ctl_q;    // Source selects and crystal enables
	logic [7:0]  drive_mode_q; // Bit 0 forces high drive
	logic        unlock_q;     // Drive register open for one write
	logic        stabilised_q; // Slow crystal has settled once
	logic        rejected_q;   // Last mode write was refused
	// Mode machine
	omc_state_t  state_q;
	omc_state_t  state_d;
	omc_state_t  ret_state_q;  // Mode to resume after standby
	omc_state_t  rec_target_q; // Where RECOVER ends
	logic [5:0]  ret_ctl_q;    // Mode control to resume
	logic [1:0]  mask_q;       // Mask level caught at entry
	logic        rec_stby_q;   // RECOVER follows standby
	logic        wake_ok;      // Qualified wake event
	logic        accept;
	logic        reject;
	logic        tmr_start;
	omc_count_t  tmr_load;
	logic        tmr_done;
	logic [10:0] pick;         // {valid, target}
	logic        want_fast;
	logic [1:0]  hand_q;       // Handover gap counter

	// Address match used for reads and writes alike
	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		hit = (a == r);
	endfunction

	// Target of a mode write from the present run mode, or invalid
	function automatic logic [10:0] pick_target(input logic from_fast,
			input logic slow_ok, input logic [5:0] v);
		logic       ok;
		omc_state_t t;
		ok = 1'b1;
		t = OMC_SLOW;
		if (v[`OMC_BIT_STOP] && v[`OMC_BIT_HALT]) begin
			ok = 1'b0;
		end else if (!v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT] && !v[`OMC_BIT_SLOWEN]) begin
			ok = 1'b0;
		end else if (!v[`OMC_BIT_HALT] && v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT] &&
				!v[`OMC_BIT_FASTEN]) begin
			ok = 1'b0;
		end else if (v[`OMC_BIT_STOP]) begin
			if (v[`OMC_BIT_FASTEN] && v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT]) begin
				t = OMC_FULL_STOP_FAST;
			end else if (!v[`OMC_BIT_FASTEN] && !v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT]) begin
				t = OMC_FULL_STOP_SLOW;
				ok = !from_fast || slow_ok;
			end else begin
				ok = 1'b0;
			end
		end else if (v[`OMC_BIT_HALT]) begin
			if (v[`OMC_BIT_FASTEN] && v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT]) begin
				t = OMC_LIGHT_SLEEP_FAST;
			end else if (v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT]) begin
				t = OMC_DEEP_SLEEP_FROM_FAST;
				ok = !from_fast || slow_ok;
			end else begin
				t = v[`OMC_BIT_DEEP] ? OMC_DEEP_SLEEP_FROM_SLOW : OMC_LIGHT_SLEEP_SLOW;
				ok = !from_fast || slow_ok;
			end
		end else if (v[`OMC_BIT_FASTEN] && v[`OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT]) begin
			t = OMC_NORMAL;
		end else if (v[`OMC_BIT_FASTEN]) begin
			t = OMC_IDLE;
		end else begin
			t = OMC_SLOW;
			ok = !from_fast || slow_ok;
		end
		pick_target = {ok, t};
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY
	assign ap_take = hsel && htrans[1] && hready;
	assign wr_mode = ap_wr_q && hit(ap_addr_q, `OMC_ADDR_MODE);

	// Address phase capture; non-word sizes behave as unmapped
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 32'h0000_0000;
		end else begin
			ap_wr_q <= ap_take && hwrite && (hsize == 3'h2);
			ap_addr_q <= {haddr[31:2], 2'h0};
		end
	end

	// Read data is prepared during the address phase
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ap_take && !hwrite) begin
			if (hsize != 3'h2) begin
				hrdata <= 32'h0000_0000;
			end else if (hit(haddr, `OMC_ADDR_MODE)) begin
				hrdata <= {26'h0, mode_control_register_q};
			end else if (hit(haddr, `OMC_ADDR_OSC)) begin
				hrdata <= {28'h0, osc_ctl_q};
			end else if (hit(haddr, `OMC_ADDR_DRIVE)) begin
				hrdata <= {24'h0, drive_mode_q};
			end else if (hit(haddr, `OMC_ADDR_UNLOCK)) begin
				hrdata <= {31'h0, unlock_q};
			end else if (hit(haddr, `OMC_ADDR_STATUS)) begin
				hrdata <= {16'h0, rejected_q, slow_osc_stable,
					fast_osc_stable, slow_osc_high_drive,
					2'h0, state_q};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Oscillator control register drives the source selects directly
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osc_ctl_q <= `OMC_OSC_RESET;
		end else if (ap_wr_q && hit(ap_addr_q, `OMC_ADDR_OSC)) begin
			osc_ctl_q <= hwdata[3:0];
		end
	end
	assign fast_source_select  = osc_ctl_q[`OMC_BIT_FSRC];
	assign ext_fast_osc_enable = osc_ctl_q[`OMC_BIT_XFEN];
	assign slow_source_select  = osc_ctl_q[`OMC_BIT_SSRC];
	assign ext_slow_osc_enable = osc_ctl_q[`OMC_BIT_XSEN];

	// Unlock then one drive write; refused unless on the internal RC
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			unlock_q <= 1'b0;
			drive_mode_q <= `OMC_DRIVE_RESET;
		end else if (ap_wr_q && hit(ap_addr_q, `OMC_ADDR_UNLOCK)) begin
			unlock_q <= (hwdata[7:0] == `OMC_UNLOCK_KEY);
		end else if (ap_wr_q && hit(ap_addr_q, `OMC_ADDR_DRIVE)) begin
			unlock_q <= 1'b0;
			if (unlock_q && !slow_source_select) begin
				drive_mode_q <= hwdata[7:0];
			end
		end
	end

	// High drive from reset until the slow crystal first settles
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stabilised_q <= 1'b0;
			slow_osc_high_drive <= 1'b1;
		end else begin
			stabilised_q <= stabilised_q | slow_osc_stable;
			slow_osc_high_drive <= drive_mode_q[0] | !stabilised_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Mode decision; writes only count in a running mode
	assign pick = pick_target(state_q == OMC_NORMAL, slow_osc_stable,
		hwdata[5:0]);
	assign accept = wr_mode && pick[10] &&
		(state_q inside {OMC_NORMAL, OMC_IDLE, OMC_SLOW});
	assign reject = wr_mode && !accept;
	// Levels at or above the entry mask never wake
	assign wake_ok = wake_req && (source_irq_level < mask_q);

	// Next state
	always_comb begin
		state_d = state_q;
		tmr_start = 1'b0;
		tmr_load = 12'h001;
		unique case (state_q)
			OMC_NORMAL, OMC_IDLE, OMC_SLOW: begin
				if (accept) begin
					state_d = omc_state_t'(pick[9:0]);
					if (pick[9:0] == OMC_NORMAL && state_q != OMC_NORMAL) begin
						// Fast crystal settles before the switch
						state_d = OMC_RECOVER;
						tmr_start = 1'b1;
						tmr_load = (state_q == OMC_IDLE) ? 12'h001 :
							12'(`OMC_FAST_STAB_CYC);
					end
				end
			end
			OMC_RECOVER: begin
				if (tmr_done && ((rec_target_q == OMC_NORMAL) ?
						fast_osc_stable : slow_osc_stable)) begin
					state_d = rec_target_q;
				end
			end
			OMC_LIGHT_SLEEP_FAST, OMC_LIGHT_SLEEP_SLOW, OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW,
			OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW: begin
				if (wake_ok) begin
					state_d = OMC_RECOVER;
					tmr_start = 1'b1;
					if (state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) begin
						tmr_load = 12'(`OMC_STOP_STAB_CYC);
					end else if (state_q inside {OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW}) begin
						tmr_load = 12'(`OMC_FAST_STAB_CYC);
					end
				end
			end
		endcase
	end

	// Stabilisation timer
	omc_wait_timer u_wait (
		.clock   (clock),
		.rst_b   (rst_b),
		.start   (tmr_start),
		.load    (tmr_load),
		.expired (tmr_done)
	);

	// State register and the context kept across standby
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= OMC_SLOW;
			ret_state_q <= OMC_SLOW;
			rec_target_q <= OMC_SLOW;
			ret_ctl_q <= `OMC_MODE_RESET;
			mask_q <= 2'h0;
			rec_stby_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (accept) begin
				// Whole write lands in one edge
				ret_state_q <= state_q;
				ret_ctl_q <= mode_control_register_q;
				mask_q <= cpu_irq_mask_level;
				rec_target_q <= OMC_NORMAL;
				rec_stby_q <= 1'b0;
			end else if (wake_ok && state_d == OMC_RECOVER) begin
				rec_target_q <= ret_state_q;
				rec_stby_q <= 1'b1;
			end
		end
	end

	// Mode control register follows accepted writes and wake-ups
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_control_register_q <= `OMC_MODE_RESET;
			rejected_q <= 1'b0;
		end else begin
			if (accept) begin
				mode_control_register_q <= hwdata[5:0];
			end else if (wake_ok && state_d == OMC_RECOVER) begin
				mode_control_register_q <= ret_ctl_q;
			end
			if (wr_mode) begin
				rejected_q <= reject;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Clock and oscillator outputs from the present mode
	assign want_fast = (state_q inside {OMC_NORMAL, OMC_LIGHT_SLEEP_FAST});

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fast_osc_run <= 1'b0;
			slow_osc_run <= 1'b1;
			cpu_clk_en <= 1'b1;
			rtc_clk_en <= 1'b1;
			watchdog_clear <= 1'b0;
			watchdog_run <= 1'b1;
		end else begin
			fast_osc_run <= (state_q inside {OMC_NORMAL, OMC_IDLE,
				OMC_LIGHT_SLEEP_FAST}) ||
				(state_q == OMC_LIGHT_SLEEP_SLOW &&
				mode_control_register_q[`OMC_BIT_FASTEN]) ||
				(state_q == OMC_RECOVER && rec_target_q == OMC_NORMAL);
			slow_osc_run <= !(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) &&
				(mode_control_register_q[`OMC_BIT_SLOWEN] ||
				!(state_q inside {OMC_NORMAL, OMC_LIGHT_SLEEP_FAST}));
			cpu_clk_en <= (state_q inside {OMC_NORMAL, OMC_IDLE,
				OMC_SLOW}) || (state_q == OMC_RECOVER && !rec_stby_q);
			rtc_clk_en <= !(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW});
			watchdog_clear <= (state_d inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) &&
				!(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW});
			watchdog_run <= !(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) &&
				!(state_q == OMC_RECOVER && rec_stby_q);
		end
	end

	// Break-before-make source switch: gate off, flip, then reopen
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hand_q <= 2'h0;
			system_clock_out_sel_fast <= 1'b0;
			system_clock_out_gate_en <= 1'b1;
		end else begin
			if (want_fast != system_clock_out_sel_fast) begin
				if (hand_q == 2'(`OMC_HANDOVER_CYC - 1)) begin
					system_clock_out_sel_fast <= want_fast;
					hand_q <= 2'h0;
				end else begin
					hand_q <= hand_q + 2'h1;
				end
			end else begin
				hand_q <= 2'h0;
			end
			system_clock_out_gate_en <= (want_fast == system_clock_out_sel_fast) &&
				!(state_q inside {OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW, OMC_FULL_STOP_FAST,
				OMC_FULL_STOP_SLOW}) && !(state_q == OMC_RECOVER && rec_stby_q);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_stop_entry;
		watchdog_clear ##0 (state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW});
	endsequence

	property p_onehot;
		@(posedge clock) disable iff (!rst_b) $onehot(state_q);
	endproperty
	a_onehot: assert property (p_onehot) else $error("state not one-hot");

	property p_drive_low;
		@(posedge clock) disable iff (!rst_b)
		slow_osc_stable && !drive_mode_q[0] ##1 !drive_mode_q[0]
		|-> ##1 !slow_osc_high_drive;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("drive not lowered");

	property p_slow_to_normal;
		@(posedge clock) disable iff (!rst_b)
		state_q == OMC_SLOW && accept && pick[9:0] == OMC_NORMAL
		|=> (state_q == OMC_RECOVER) [*8];
	endproperty
	a_slow_to_normal: assert property (p_slow_to_normal)
		else $error("normal entered without wait");

	property p_recover_slow;
		@(posedge clock) disable iff (!rst_b)
		state_q == OMC_RECOVER && !rec_stby_q |=> !system_clock_out_sel_fast;
	endproperty
	a_recover_slow: assert property (p_recover_slow)
		else $error("fast clock before normal");

	property p_deep_halt;
		@(posedge clock) disable iff (!rst_b)
		(state_q inside {OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW}) ##1
		(state_q inside {OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW})
		|-> !fast_osc_run && slow_osc_run && !cpu_clk_en && rtc_clk_en;
	endproperty
	a_deep_halt: assert property (p_deep_halt)
		else $error("deep halt clocks wrong");

	property p_mask;
		@(posedge clock) disable iff (!rst_b)
		(state_q inside {OMC_LIGHT_SLEEP_FAST, OMC_LIGHT_SLEEP_SLOW, OMC_DEEP_SLEEP_FROM_FAST, OMC_DEEP_SLEEP_FROM_SLOW,
		OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) && source_irq_level >= mask_q
		|=> $stable(state_q);
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked level woke device");

	property p_stop_osc;
		@(posedge clock) disable iff (!rst_b)
		(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW}) ##1
		(state_q inside {OMC_FULL_STOP_FAST, OMC_FULL_STOP_SLOW})
		|-> !fast_osc_run && !slow_osc_run && !cpu_clk_en;
	endproperty
	a_stop_osc: assert property (p_stop_osc)
		else $error("oscillator runs in stop");

	property p_wdt;
		@(posedge clock) disable iff (!rst_b)
		s_stop_entry |=> !watchdog_run;
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog runs in stop");

	property p_reject;
		@(posedge clock) disable iff (!rst_b)
		wr_mode && hwdata[`OMC_BIT_STOP] && hwdata[`OMC_BIT_HALT]
		|=> $stable(mode_control_register_q) && rejected_q;
	endproperty
	a_reject: assert property (p_reject)
		else $error("invalid mode write taken");

	property p_glitch;
		@(posedge clock) disable iff (!rst_b)
		$changed(system_clock_out_sel_fast) |-> !system_clock_out_gate_en;
	endproperty
	a_glitch: assert property (p_glitch)
		else $error("source switched with gate open");

endmodule

// ==== hw/omc_params.svh ====
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

// Register byte addresses on the AHB-Lite port
`define OMC_ADDR_UNLOCK 32'h0000_3d80
`define OMC_ADDR_DRIVE  32'h0000_3d8c
`define OMC_ADDR_MODE   32'h0000_3f00
`define OMC_ADDR_OSC    32'h0000_3f08
`define OMC_ADDR_STATUS 32'h0000_3f0c

// Mode control field positions
`define OMC_BIT_STOP  5
`define OMC_BIT_HALT  4
`define OMC_BIT_DEEP  3
`define OMC_BIT_SLOWEN 2
`define OMC_BIT_FASTEN 1
`define OMC_BIT_SYSTEM_CLOCK_SOURCE_SELECT 0

// Oscillator control field positions
`define OMC_BIT_FSRC  0
`define OMC_BIT_XFEN  1
`define OMC_BIT_SSRC  2
`define OMC_BIT_XSEN  3

// Reset values
`define OMC_MODE_RESET  6'h04
`define OMC_OSC_RESET   4'h8
`define OMC_DRIVE_RESET 8'h00

// Unlock key for the drive-strength register (arbitrary value)
`define OMC_UNLOCK_KEY  8'h5a

// Timing
`define OMC_CLK_PERIOD_NS 100
`define OMC_FAST_STAB_NS  100000
`define OMC_STOP_STAB_NS  200000
`define OMC_FAST_STAB_CYC \
	((`OMC_FAST_STAB_NS + `OMC_CLK_PERIOD_NS - 1) / `OMC_CLK_PERIOD_NS)
`define OMC_STOP_STAB_CYC \
	((`OMC_STOP_STAB_NS + `OMC_CLK_PERIOD_NS - 1) / `OMC_CLK_PERIOD_NS)
`define OMC_HANDOVER_CYC 2

`endif

// ==== hw/omc_pkg.sv ====
package omc_pkg;

	// Operating states, one-hot
	typedef enum logic [9:0] {
		OMC_NORMAL  = 10'b00_0000_0001,
		OMC_IDLE    = 10'b00_0000_0010,
		OMC_SLOW    = 10'b00_0000_0100,
		OMC_RECOVER = 10'b00_0000_1000,
		OMC_LIGHT_SLEEP_FAST   = 10'b00_0001_0000,
		OMC_LIGHT_SLEEP_SLOW   = 10'b00_0010_0000,
		OMC_DEEP_SLEEP_FROM_FAST   = 10'b00_0100_0000,
		OMC_DEEP_SLEEP_FROM_SLOW   = 10'b00_1000_0000,
		OMC_FULL_STOP_FAST   = 10'b01_0000_0000,
		OMC_FULL_STOP_SLOW   = 10'b10_0000_0000
	} omc_state_t;

	// Width of the stabilisation counter
	typedef logic [11:0] omc_count_t;

endpackage

// ==== hw/omc_wait_timer.sv ====
`timescale 1ns/1ns
`include "omc_params.svh"

// Down counter for oscillator stabilisation waits
module omc_wait_timer
	import omc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       start,
	input  wire omc_count_t load,
	output logic            expired
);
	import omc_pkg::*;

	omc_count_t cnt_q; // Remaining cycles

	// Load on start, then count down to zero and rest there
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 12'h000;
		end else if (start) begin
			cnt_q <= load;
		end else if (cnt_q != 12'h000) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end

	// Start hides a stale zero in the same cycle
	assign expired = (cnt_q == 12'h000) && !start;

endmodule

// ==== verification/omc_osc_model.sv ====
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Oscillator pair: each settles a fixed time after enable and drops at once
// when disabled, so no stale stable flag survives a stop
module omc_osc_model #(
	parameter int STAB = 20
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic fast_osc_run,
	input  wire logic slow_osc_run,
	output logic      fast_osc_stable,
	output logic      slow_osc_stable
);
	// Fast source taken as ample against slow; no peripherals here
	int fcnt_q;  // Cycles since fast enable
	int scnt_q;  // Cycles since slow enable
	// Count while enabled, clear when disabled
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fcnt_q <= 0;
			scnt_q <= 0;
		end else begin
			fcnt_q <= fast_osc_run ? ((fcnt_q < STAB) ? fcnt_q + 1 : fcnt_q) : 0;
			scnt_q <= slow_osc_run ? ((scnt_q < STAB) ? scnt_q + 1 : scnt_q) : 0;
		end
	end
	assign fast_osc_stable = (fcnt_q >= STAB);
	assign slow_osc_stable = (scnt_q >= STAB);
endmodule

// ==== verification/tb_operating_mode_clock_controller.sv ====
`timescale 1ns/1ns
`include "omc_params.svh"
//////////////////////////////////////////////////////////////////////////////
module tb_operating_mode_clock_controller;
	import omc_pkg::*;
	logic        clock, rst_b, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, source_irq_level, cpu_irq_mask_level;
	logic [2:0]  hsize;
	logic        fast_osc_stable, slow_osc_stable, wake_req;
	logic        fast_osc_run, slow_osc_run, slow_osc_high_drive;
	logic        system_clock_out_sel_fast, system_clock_out_gate_en, cpu_clk_en;
	logic        watchdog_clear, watchdog_run;
	logic        rtc_clk_en, ext_fast_osc_enable, fast_source_select;
	logic        ext_slow_osc_enable, slow_source_select;
	int          miscompares, checks, wd_hits;
	assign hready = hreadyout;  // Single slave drives the bus ready
	omc_mode_ctrl uut (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.fast_osc_stable(fast_osc_stable), .slow_osc_stable(slow_osc_stable),
		.wake_req(wake_req), .source_irq_level(source_irq_level),
		.cpu_irq_mask_level(cpu_irq_mask_level), .fast_osc_run(fast_osc_run),
		.slow_osc_run(slow_osc_run), .slow_osc_high_drive(slow_osc_high_drive),
		.ext_fast_osc_enable(ext_fast_osc_enable),
		.fast_source_select(fast_source_select),
		.ext_slow_osc_enable(ext_slow_osc_enable),
		.slow_source_select(slow_source_select),
		.system_clock_out_sel_fast(system_clock_out_sel_fast), .system_clock_out_gate_en(system_clock_out_gate_en),
		.cpu_clk_en(cpu_clk_en), .rtc_clk_en(rtc_clk_en),
		.watchdog_clear(watchdog_clear), .watchdog_run(watchdog_run));
	omc_osc_model osc (.clock(clock), .rst_b(rst_b),
		.fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
		.fast_osc_stable(fast_osc_stable), .slow_osc_stable(slow_osc_stable));
	// 100 ns clock
	always #50 clock = ~clock;
	// Count watchdog clear pulses
	always @(posedge clock) begin
		if (watchdog_clear === 1'b1) wd_hits++;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One single-word transfer; read data taken at the data-phase edge
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rd_chk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	// Poll the state field for up to n reads, then compare
	task wait_st(input logic [9:0] m, input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			bus(1'b0, `OMC_ADDR_STATUS, 32'h0, r);
			if (r[9:0] === m) break;
		end
		chk({22'h0, r[9:0]}, {22'h0, m});
	endtask
	// Enter standby, refuse a masked wake, then wake and check the return
	task standby(input logic [5:0] v, input logic [9:0] s, input logic [9:0] b,
		input logic [5:0] bm, input logic [2:0] e);
		int n;
		n = wd_hits;
		wr(`OMC_ADDR_MODE, {26'h0, v});
		wait_st(s, 1);
		repeat (3) @(posedge clock);  // Let a clock handover settle
		chk({fast_osc_run, slow_osc_run, system_clock_out_gate_en}, e);
		chk({cpu_clk_en, rtc_clk_en}, {1'b0, e != 3'b000});
		chk(wd_hits, (e == 3'b000) ? n + 1 : n);
		wake_req <= 1'b1;
		source_irq_level <= 2'h2;
		repeat (20) @(posedge clock);
		wait_st(s, 1);
		source_irq_level <= 2'h1;
		repeat (4) @(posedge clock);
		if (e == 3'b000) chk(watchdog_run, 1'b0);
		wait_st(b, 2000);
		wake_req <= 1'b0;
		rd_chk(`OMC_ADDR_MODE, {26'h0, bm});
	endtask
	// Reset values, unmapped read, drive current lowering
	task t_reset;
		rd_chk(`OMC_ADDR_MODE, 32'h4);
		rd_chk(32'h0000_3f04, 32'h0);
		wait_st(OMC_SLOW, 1);
		chk(slow_osc_high_drive, 1'b1);
		for (int i = 0; i < 3000 && slow_osc_high_drive; i++) @(posedge clock);
		chk(slow_osc_high_drive, 1'b0);
		wr(`OMC_ADDR_UNLOCK, {24'h0, `OMC_UNLOCK_KEY});
		wr(`OMC_ADDR_DRIVE, 32'h1);
		repeat (2) @(posedge clock);
		chk(slow_osc_high_drive, 1'b1);
		chk({hresp, hreadyout}, 2'b01);
		wr(`OMC_ADDR_OSC, 32'ha);
		wr(`OMC_ADDR_OSC, 32'hf);
		rd_chk(`OMC_ADDR_OSC, 32'hf);
		chk({ext_fast_osc_enable, fast_source_select, ext_slow_osc_enable,
			slow_source_select}, 4'hf);
		// Drive rewrite refused while on the slow crystal
		wr(`OMC_ADDR_UNLOCK, {24'h0, `OMC_UNLOCK_KEY});
		wr(`OMC_ADDR_DRIVE, 32'h0);
		rd_chk(`OMC_ADDR_DRIVE, 32'h1);
		chk(slow_osc_high_drive, 1'b1);
	endtask
	// Every standby entry from SLOW except LIGHT_SLEEP_FAST
	task t_from_slow;
		standby(6'h1c, OMC_DEEP_SLEEP_FROM_SLOW, OMC_SLOW, 6'h04, 3'b010);
		standby(6'h14, OMC_LIGHT_SLEEP_SLOW, OMC_SLOW, 6'h04, 3'b011);
		standby(6'h24, OMC_FULL_STOP_SLOW, OMC_SLOW, 6'h04, 3'b000);
		standby(6'h15, OMC_DEEP_SLEEP_FROM_FAST, OMC_SLOW, 6'h04, 3'b010);
		standby(6'h27, OMC_FULL_STOP_FAST, OMC_SLOW, 6'h04, 3'b000);
	endtask
	// SLOW to NORMAL keeps the slow clock through the fast wait
	task t_to_normal;
		wr(`OMC_ADDR_MODE, 32'h7);
		wait_st(OMC_RECOVER, 1);
		chk(system_clock_out_sel_fast, 1'b0);
		repeat (500) @(posedge clock);
		wait_st(OMC_RECOVER, 1);
		chk(system_clock_out_sel_fast, 1'b0);
		wait_st(OMC_NORMAL, 2000);
		repeat (4) @(posedge clock);
		chk({system_clock_out_sel_fast, system_clock_out_gate_en}, 2'b11);
	endtask
	// Invalid mode values leave state and register alone
	task t_reject;
		logic [31:0] r;
		wr(`OMC_ADDR_MODE, 32'h37);
		bus(1'b0, `OMC_ADDR_STATUS, 32'h0, r);
		chk({r[15], r[9:0]}, {1'b1, OMC_NORMAL});
		wr(`OMC_ADDR_MODE, 32'h02);
		bus(1'b0, `OMC_ADDR_STATUS, 32'h0, r);
		chk({r[15], r[9:0]}, {1'b1, OMC_NORMAL});
		rd_chk(`OMC_ADDR_MODE, 32'h7);
	endtask
	// NORMAL through IDLE on the slow clock and back
	task t_idle;
		wr(`OMC_ADDR_MODE, 32'h6);
		wait_st(OMC_IDLE, 1);
		repeat (4) @(posedge clock);
		chk({system_clock_out_sel_fast, system_clock_out_gate_en, fast_osc_run}, 3'b011);
		wr(`OMC_ADDR_MODE, 32'h7);
		wait_st(OMC_NORMAL, 20);
		repeat (4) @(posedge clock);
		chk({system_clock_out_sel_fast, system_clock_out_gate_en}, 2'b11);
	endtask
	// Every standby entry from NORMAL
	task t_from_normal;
		standby(6'h17, OMC_LIGHT_SLEEP_FAST, OMC_NORMAL, 6'h07, 3'b111);
		standby(6'h15, OMC_DEEP_SLEEP_FROM_FAST, OMC_NORMAL, 6'h07, 3'b010);
		standby(6'h23, OMC_FULL_STOP_FAST, OMC_NORMAL, 6'h07, 3'b000);
		standby(6'h14, OMC_LIGHT_SLEEP_SLOW, OMC_NORMAL, 6'h07, 3'b011);
		standby(6'h1c, OMC_DEEP_SLEEP_FROM_SLOW, OMC_NORMAL, 6'h07, 3'b010);
		standby(6'h24, OMC_FULL_STOP_SLOW, OMC_NORMAL, 6'h07, 3'b000);
	endtask
	task tally_and_finish;
		if (miscompares == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Hang guard, well past the longest expected run
	initial begin
		#6_000_000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		wake_req = 1'b0;
		source_irq_level = 2'h0;
		cpu_irq_mask_level = 2'h2;
		miscompares = 0;
		checks = 0;
		wd_hits = 0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_from_slow();
		t_to_normal();
		t_reject();
		t_idle();
		t_from_normal();
		tally_and_finish();
	end
endmodule
